// File: low_voltage_reset_monitor.sv
`timescale 1ns/1ps
// What this block does
// [RULE1] Monitor comes out of any reset enabled.
// [RULE2] Supply is watched only while power enable is set.
// [RULE3] Reset needs nine consecutive low cycles with reset enable set.
// [RULE4] Reset holds until above rising level for one cycle.
// [RULE5] Monitor reset also pulls the external reset pin low.
// [RULE6] Flag is 1 below falling level, 0 above rising, else held.
// [RULE7] Flag is read-only and cleared by any system reset.
// [RULE8] Monitor never raises an interrupt.
// [RULE9] Polled use: software sets power enable 1, reset enable 0.
// [RULE10] Forced reset use: software sets power and reset enable to 1.
// [RULE11] Enables come from the configuration register bits.
// [RULE12] With power enable set, monitor stays active in wait mode.
// [RULE13] Trip during wait mode gives a reset that ends wait.
// [RULE14] Active in stop only with stop and power enable; trip ends stop.
// [RULE15] Power enable with stop enable clear goes inactive in stop.
// [RULE16] Low-cycle counter restarts on any cycle above the falling level.
module low_voltage_reset_monitor
  import lvm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic comp_below_fall_i,
  input wire logic comp_above_rise_i,
  input wire logic wait_mode_i,
  input wire logic stop_mode_i,
  output logic monitor_reset_o,
  output logic ext_reset_b_o,
  output logic ext_reset_oe_o,
  output logic wake_o,
  output logic below_trip_flag_o
);

  typedef struct packed {
    mon_state_t state;
    logic [7:0] config_reg;
    logic flag;
    logic rst_out;
  } mon_t;

  mon_t cur_ff;
  mon_t nxt_cur;
  comp_t comp;
  logic active;
  logic tripped;
  logic cfg_we;
  logic [7:0] cfg_wdata;
  logic [7:0] status_rd;

  //////////////////////////////////////////////////////////////////////////////
  // Comparator outputs grouped for the state logic.
  assign comp.below_fall = comp_below_fall_i;
  assign comp.above_rise = comp_above_rise_i;

  // Enables come only from the configuration register; the status register
  // holds no control bits so software cannot disable the monitor through it.
  // Wait mode does not gate the monitor, stop mode does unless stop enable.
  assign active = cur_ff.config_reg[PWR_BIT] // RULE2 RULE11 RULE12
    && (!stop_mode_i || cur_ff.config_reg[STOP_BIT]); // RULE14 RULE15

  // Status register: only the flag, reserved bits read zero.
  assign status_rd = {cur_ff.flag, 7'h00}; // RULE7

  //////////////////////////////////////////////////////////////////////////////
  // Register bus slave.
  lvm_bus_slave u_slave (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .address_i(avs_address_i),
    .read_i(avs_read_i),
    .write_i(avs_write_i),
    .writedata_i(avs_writedata_i),
    .status_i(status_rd),
    .config_i(cur_ff.config_reg),
    .readdata_o(avs_readdata_o),
    .waitrequest_o(avs_waitrequest_o),
    .cfg_we_o(cfg_we),
    .cfg_wdata_o(cfg_wdata)
  );

  // Consecutive-cycle filter for the falling trip.
  lvm_filter u_filter (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i && !cur_ff.rst_out),
    .active_i(active && cur_ff.config_reg[RST_BIT]),
    .below_i(comp.below_fall),
    .tripped_o(tripped)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic for configuration, flag and reset sequencing.
  always_comb begin
    nxt_cur = cur_ff;
    if (cfg_we && !cur_ff.rst_out) begin
      nxt_cur.config_reg = cfg_wdata;
    end
    // Hysteresis flag; it cannot be written, only follows the comparator.
    if (active && comp.below_fall) begin
      nxt_cur.flag = 1'b1; // RULE6
    end else if (active && comp.above_rise) begin
      nxt_cur.flag = 1'b0; // RULE6
    end
    case (cur_ff.state)
      ST_WATCH: begin
        if (active && cur_ff.config_reg[RST_BIT] && comp.below_fall) begin
          nxt_cur.state = ST_FILTER;
        end
      end
      ST_FILTER: begin
        if (!comp.below_fall || !active || !cur_ff.config_reg[RST_BIT]) begin
          nxt_cur.state = ST_WATCH; // RULE16
        end else if (tripped) begin
          nxt_cur.state = ST_RESET; // RULE3
          nxt_cur.rst_out = 1'b1; // RULE13 RULE14
        end
      end
      ST_RESET: begin
        // A single cycle above the rising level releases the reset.
        if (comp.above_rise) begin
          nxt_cur.state = ST_WATCH; // RULE4
          nxt_cur.rst_out = 1'b0;
          nxt_cur.flag = 1'b0; // RULE7
          nxt_cur.config_reg = CONFIG_RESET; // RULE1
        end
      end
      default: begin
        nxt_cur.state = ST_WATCH;
        nxt_cur.rst_out = 1'b0;
      end
    endcase
  end

  // System reset restores an enabled monitor and clears the flag.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cur_ff.state <= ST_WATCH;
      cur_ff.config_reg <= CONFIG_RESET; // RULE1
      cur_ff.flag <= 1'b0; // RULE7
      cur_ff.rst_out <= 1'b0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs. The reset pin is open drain: driven low only during a trip.
  assign monitor_reset_o = cur_ff.rst_out;
  assign ext_reset_b_o = 1'b0;
  assign ext_reset_oe_o = cur_ff.rst_out; // RULE5
  // A trip reset doubles as the wake request out of wait or stop.
  assign wake_o = cur_ff.rst_out && (wait_mode_i || stop_mode_i); // RULE13 RULE14
  assign below_trip_flag_o = cur_ff.flag;
  // No interrupt output exists on this block. RULE8

endmodule // low_voltage_reset_monitor

// File: low_voltage_reset_monitor_asserts.sv
`timescale 1ns/1ps
// Watches only the monitor's ports.
module lvm_chk (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic comp_below_fall_i,
  input wire logic comp_above_rise_i,
  input wire logic wait_mode_i,
  input wire logic stop_mode_i,
  input wire logic monitor_reset_o,
  input wire logic ext_reset_b_o,
  input wire logic ext_reset_oe_o,
  input wire logic wake_o,
  input wire logic below_trip_flag_o
);
  logic [3:0] run_ff;
  logic ok9_ff;
  // A full run stays remembered until the reset lands, since the trip may lag the run.
  always_ff @(posedge mclk_i) begin
    run_ff <= (!rst_b_i || !comp_below_fall_i) ? 4'h0 : run_ff + {3'h0, run_ff != 4'hF};
    ok9_ff <= rst_b_i && !monitor_reset_o && !comp_above_rise_i &&
      (ok9_ff || (run_ff >= 4'h8 && comp_below_fall_i));
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  AST_TRIP_RUN: assert property ($rose(monitor_reset_o) |-> ok9_ff)
    else $error("reset without a full low run");
  AST_RELEASE: assert property (monitor_reset_o && comp_above_rise_i |-> ##[1:2] !monitor_reset_o)
    else $error("reset not released");
  AST_HOLD: assert property (monitor_reset_o && !comp_above_rise_i && !$past(comp_above_rise_i)
    |=> monitor_reset_o)
    else $error("reset dropped early");
  AST_PIN: assert property (ext_reset_oe_o == monitor_reset_o && ext_reset_b_o == 1'b0)
    else $error("reset pin mismatch");
  AST_FLAG_RISE: assert property ($rose(below_trip_flag_o) |-> $past(comp_below_fall_i))
    else $error("flag set without low supply");
  AST_FLAG_FALL: assert property ($fell(below_trip_flag_o)
    |-> $past(comp_above_rise_i) || $past(monitor_reset_o) || monitor_reset_o)
    else $error("flag cleared without cause");
  AST_FLAG_HOLD: assert property (!comp_below_fall_i && !comp_above_rise_i && !monitor_reset_o
    |=> $stable(below_trip_flag_o) || monitor_reset_o)
    else $error("flag moved in band");
  AST_WAKE: assert property (wake_o == (monitor_reset_o && (wait_mode_i || stop_mode_i)))
    else $error("wake mismatch");
  cover property ($rose(monitor_reset_o));
  cover property ($rose(wake_o));
  cover property ($fell(below_trip_flag_o) && !monitor_reset_o);
endmodule // lvm_chk

bind low_voltage_reset_monitor lvm_chk chk_u (.mclk_i, .rst_b_i, .comp_below_fall_i,
  .comp_above_rise_i, .wait_mode_i, .stop_mode_i, .monitor_reset_o, .ext_reset_b_o,
  .ext_reset_oe_o, .wake_o, .below_trip_flag_o);

// File: lvm_bus_slave.sv
`timescale 1ns/1ps
// Avalon-MM slave: answers every access in the cycle after it appears.
module lvm_bus_slave
  import lvm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [3:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [7:0] status_i,
  input wire logic [7:0] config_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  output logic cfg_we_o,
  output logic [7:0] cfg_wdata_o
);

  typedef struct packed {
    logic done;
    logic [31:0] rdata;
  } slv_t;

  slv_t cur_ff;
  slv_t nxt_cur;

  //////////////////////////////////////////////////////////////////////////////
  // One wait cycle per access so read data comes from a flip-flop.
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.done = (read_i || write_i) && !cur_ff.done;
    if (read_i && !cur_ff.done) begin
      case (address_i)
        ADDR_STATUS: nxt_cur.rdata = {24'h000000, status_i};
        ADDR_CONFIG: nxt_cur.rdata = {24'h000000, config_i};
        default: nxt_cur.rdata = UNMAPPED_DATA;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign waitrequest_o = (read_i || write_i) && !cur_ff.done;
  assign readdata_o = cur_ff.rdata;
  // A write lands at the edge where waitrequest is low.
  assign cfg_we_o = write_i && cur_ff.done && (address_i == ADDR_CONFIG);
  assign cfg_wdata_o = writedata_i[7:0];

endmodule // lvm_bus_slave

// File: lvm_filter.sv
`timescale 1ns/1ps
// Counts consecutive low-supply cycles.
module lvm_filter
  import lvm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic active_i,
  input wire logic below_i,
  output logic tripped_o
);

  typedef struct packed {
    logic [3:0] cnt;
  } flt_t;

  flt_t cur_ff;
  flt_t nxt_cur;

  //////////////////////////////////////////////////////////////////////////////
  // Count saturates at the trip length; any good cycle restarts it.
  always_comb begin
    nxt_cur = cur_ff;
    if (!active_i || !below_i) begin
      nxt_cur.cnt = 4'h0; // RULE16
    end else if (cur_ff.cnt != TRIP_CYCLES) begin
      nxt_cur.cnt = cur_ff.cnt + 4'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Trips in the cycle that brings the ninth consecutive low sample. The reset then
  // lands on that same edge, and a dip of eight cycles never reaches it.
  assign tripped_o = active_i && below_i && (cur_ff.cnt >= TRIP_CYCLES - 4'h1); // RULE3

endmodule // lvm_filter

// File: lvm_pkg.sv
package lvm_pkg;

  // Register map: each register takes one aligned 32-bit word.
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CONFIG = 4'h4;

  // Field positions in the status register.
  localparam int FLAG_BIT = 7;

  // Field positions in the device configuration register.
  localparam int PWR_BIT = 0;
  localparam int RST_BIT = 1;
  localparam int STOP_BIT = 2;

  // Configuration value after reset: power and reset enabled, stop enable clear.
  localparam logic [7:0] CONFIG_RESET = 8'h03;

  // Low-supply filter length and release length, in CPU cycles.
  localparam logic [3:0] TRIP_CYCLES = 4'h9;
  localparam logic [3:0] RELEASE_CYCLES = 4'h1;

  // Answer for unmapped reads.
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // Comparator outputs travel together.
  typedef struct packed {
    logic below_fall;
    logic above_rise;
  } comp_t;

  typedef enum logic [2:0] {
    ST_WATCH = 3'b001,
    ST_FILTER = 3'b010,
    ST_RESET = 3'b100
  } mon_state_t;

endpackage

// File: supply_comparator_model.sv
`timescale 1ns/1ps
// Comparator pair: level 0 low, 1 inside the band, 2 high; the band gives hysteresis.
module supply_comparator_model
  import lvm_pkg::*;
(
  input wire logic [1:0] level_i,
  output comp_t comp_o
);
  // Both outputs can never be high together.
  assign comp_o.below_fall = (level_i == 2'h0);
  assign comp_o.above_rise = (level_i == 2'h2);
endmodule // supply_comparator_model

// File: test_low_voltage_reset_monitor.sv
`timescale 1ns/1ps
module test_low_voltage_reset_monitor;
  import lvm_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic wait_m = 1'b0;
  logic stop_m = 1'b0;
  logic [1:0] lvl = 2'h2;
  logic [31:0] rdata;
  logic [31:0] q;
  comp_t comp;
  logic wreq, mon, ext_b, oe, wake, flag;
  int n_mismatch = 0;
  int total_checks = 0;
  // Clock toggles every half period.
  always #2.5 mclk_i = ~mclk_i;
  supply_comparator_model cmp_u (.level_i(lvl), .comp_o(comp));
  low_voltage_reset_monitor dut_u (.mclk_i, .rst_b_i, .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .comp_below_fall_i(comp.below_fall), .comp_above_rise_i(comp.above_rise),
    .wait_mode_i(wait_m), .stop_mode_i(stop_m), .monitor_reset_o(mon), .ext_reset_b_o(ext_b),
    .ext_reset_oe_o(oe), .wake_o(wake), .below_trip_flag_o(flag));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Holds the request until waitrequest is seen low, then idles one cycle.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int i;
    i = 0;
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= {24'h0, d};
    do begin
      @(posedge mclk_i);
      i++;
    end while (wreq !== 1'b0 && i < 20);
    if (wreq !== 1'b0) begin
      n_mismatch++;
      wrap_up();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk_i);
  endtask
  // Holds a supply level for n sampling edges.
  task automatic sup(input logic [1:0] l, input int n);
    lvl <= l;
    repeat (n) @(posedge mclk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    bus(1'b0, ADDR_CONFIG, 8'h00);
    chk(q[7:0], 8'h03);
    bus(1'b1, ADDR_STATUS, 8'h80);
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk(q[7:0], 8'h00);
    bus(1'b0, 4'h8, 8'h00);
    chk(q[7:0], 8'h00);
  endtask
  // Two eight-cycle dips split by one good cycle must not trip.
  task automatic t_dips();
    sup(2'h0, 8);
    sup(2'h1, 1);
    sup(2'h0, 8);
    sup(2'h1, 4);
    chk(8'(mon), 8'h00);
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk(q[7:0], 8'h80);
    sup(2'h2, 2);
    chk(8'(flag), 8'h00);
  endtask
  // A system reset after a short dip clears a set flag and brings back the enabled monitor.
  task automatic t_sysrst();
    bus(1'b1, ADDR_CONFIG, 8'h01);
    sup(2'h0, 2);
    sup(2'h1, 1);
    chk(8'(flag), 8'h01);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    chk(8'(flag), 8'h00);
    bus(1'b0, ADDR_CONFIG, 8'h00);
    chk(q[7:0], CONFIG_RESET);
  endtask
  // Runs a long low spell under a given config and mode.
  task automatic t_quiet(input logic [7:0] cfg, input logic st, input logic [7:0] f);
    bus(1'b1, ADDR_CONFIG, cfg);
    stop_m <= st;
    sup(2'h0, 12);
    chk(8'(mon), 8'h00);
    chk(8'(flag), f);
    stop_m <= 1'b0;
    sup(2'h2, 2);
  endtask
  task automatic t_trip(input logic w);
    int i;
    i = 0;
    sup(2'h0, 9);
    lvl <= 2'h1;
    while (mon !== 1'b1 && i < 8) begin
      @(posedge mclk_i);
      i++;
    end
    chk(8'(mon), 8'h01);
    if (mon !== 1'b1) begin
      wrap_up();
    end
    chk({5'h00, oe, ext_b, wake}, {5'h00, 1'b1, 1'b0, w});
    sup(2'h2, 3);
    chk(8'(mon), 8'h00);
    bus(1'b0, ADDR_CONFIG, 8'h00);
    chk(q[7:0], CONFIG_RESET);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    t_regs();
    t_dips();
    t_sysrst();
    t_quiet(8'h00, 1'b0, 8'h00);
    t_quiet(8'h01, 1'b0, 8'h01);
    t_quiet(8'h03, 1'b1, 8'h00);
    t_trip(1'b0);
    wait_m <= 1'b1;
    t_trip(1'b1);
    wait_m <= 1'b0;
    bus(1'b1, ADDR_CONFIG, 8'h07);
    stop_m <= 1'b1;
    t_trip(1'b1);
    wrap_up();
  end
endmodule // test_low_voltage_reset_monitor
